// ==== hw/dcp_cfg.svh ====
// Constants of the control-pin block and its glue partner
`ifndef DCP_CFG_SVH
`define DCP_CFG_SVH
`define DCP_OFF_FLAGCTL 12'h000
`define DCP_OFF_DSTAT 12'h004
`define DCP_OFF_GCTRL 12'h000
`define DCP_OFF_GSTAT 12'h004
`define DCP_DIR0 1
`define DCP_OUT0 2
`define DCP_IN0 3
`define DCP_DIR1 5
`define DCP_OUT1 6
`define DCP_IN1 7
`define DCP_FLAGCTL_RST 32'h0000_0000
`define DCP_GCTRL_RST 32'h0000_0001
`define DCP_G_HOLD 0
`define DCP_G_BOOT 1
`define DCP_G_INT_LO 4
`define DCP_G_F1VAL 8
`define DCP_G_F1OE 9
`define DCP_WS_MP 3'h7
`define DCP_WS_MC 3'h0
`define DCP_RESET_VEC 24'h00_0000
`define DCP_LAST_FETCH 1'b1
`define DCP_RESET_HOLD 4'ha
`endif

// ==== hw/dcp_pkg.sv ====
// Types shared by both ends of the control-pin link
package dcp_pkg;
  typedef enum {ST_RESET, ST_BOOT, ST_IDLE, ST_STORE_WAIT, ST_STORE, ST_SIG_LOW, ST_SIG_MID,
    ST_SIG_HIGH, ST_INTERRUPT_ACKNOWLEDGE_OUT} dcp_state_t;
  typedef enum logic [1:0] {OP_STORE_INT, OP_STORE_FLOAT, OP_SIGNAL, OP_INTERRUPT_ACKNOWLEDGE_OUT} dcp_op_t;
endpackage

// ==== hw/dcp_link_if.sv ====
// Pin-level link between the processor control pins and the glue logic
`timescale 1ns/1ps
interface dcp_link_if;
  logic h1;
  logic h3;
  logic reset_n;
  logic boot_mode_select;
  logic [3:0] ext_int_n;
  logic interrupt_acknowledge_out_n;
  logic [1:0] strb_n;
  logic peripheral_io_strobe_n;
  logic rw_o;
  logic rw_oe;
  logic [23:0] addr;
  logic addr_oe;
  logic data_oe;
  logic async_oe;
  logic [1:0] dev_flag_o;
  logic [1:0] dev_flag_oe;
  logic [1:0] glue_flag_o;
  logic [1:0] glue_flag_oe;
  logic [1:0] flag_lvl;
  logic rw_lvl;
  // Wire levels, weak pull-up when nobody drives
  assign flag_lvl[0] = dev_flag_oe[0] ? dev_flag_o[0] : (glue_flag_oe[0] ? glue_flag_o[0] : 1'b1);
  assign flag_lvl[1] = dev_flag_oe[1] ? dev_flag_o[1] : (glue_flag_oe[1] ? glue_flag_o[1] : 1'b1);
  assign rw_lvl = rw_oe ? rw_o : 1'b1;
  modport dev (input reset_n, boot_mode_select, ext_int_n, flag_lvl,
    output h1, h3, interrupt_acknowledge_out_n, strb_n, peripheral_io_strobe_n, rw_o, rw_oe, addr, addr_oe, data_oe, async_oe,
    dev_flag_o, dev_flag_oe);
  modport glue (input h1, h3, interrupt_acknowledge_out_n, strb_n, peripheral_io_strobe_n, rw_lvl, addr, addr_oe, data_oe,
    async_oe, flag_lvl, output reset_n, boot_mode_select, ext_int_n, glue_flag_o, glue_flag_oe);
endinterface

// ==== hw/dcp_device.sv ====
// Processor control-pin logic: phases, flags, reset sequence, interrupts, acknowledge
//
// Behaviour
// - Interlocked store raises flag zero at h3
// - Unstalled store drives address at execute start
// - Stalled store withholds address until it executes
// - Signal instruction pulses flag zero low, h3-timed
// - Signal samples flag one at h1 fall
// - Output bits reach pins at next h3
// - Direction bits 1 and 5 select drive
// - Input pins sampled into bits 3, 7
// - Direction change takes effect at h3
// - Reset pin accepted asynchronously, synchronised sequence
// - Reset held ten h1 cycles by source
// - Reset floats data then address bus
// - Reset parks strobes and acknowledge high
// - Read/write output floats during reset
// - Reset floats flags, serial, timer pins immediately
// - Two vector fetches, seven or zero waits
// - Interrupt inputs sampled at h1 fall
// - Level interrupts held one to two cycles
// - Edge interrupts held one full cycle
// - Acknowledge spans bus cycle including waits
// - Acknowledge from decode h1 to read h1
// - Decode stretch does not lengthen acknowledge
`timescale 1ns/1ps
module dcp_device
  import dcp_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // APB slave for the flag control and status words
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Instruction requests from the core
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic [23:0] cmd_addr,
  input wire logic cmd_conflict,
  input wire logic [2:0] cmd_wait,
  output logic cmd_ready,
  output logic cmd_done,
  output logic sig_sample,
  output logic [3:0] int_seen,
  output logic running,
  // Pins
  dcp_link_if.dev link
);
`include "dcp_cfg.svh"

  dcp_state_t state_reg;
  dcp_op_t op_reg;
  logic ph_reg;
  logic h1_reg;
  logic h3_reg;
  logic rs1_reg;
  logic rs2_reg;
  logic [31:0] ctl_reg;
  logic [1:0] in_reg;
  logic [1:0] flag_o_reg;
  logic [1:0] flag_dir_reg;
  logic async_oe_reg;
  logic [23:0] addr_reg;
  logic [23:0] cmd_addr_reg;
  logic addr_oe_reg;
  logic data_oe_reg;
  logic [1:0] strb_n_reg;
  logic peripheral_io_strobe_n_reg;
  logic rw_reg;
  logic rw_oe_reg;
  logic interrupt_acknowledge_out_n_reg;
  logic busy_reg;
  logic fetch_reg;
  logic [2:0] wait_reg;
  logic [2:0] ws_reg;

  // Phase decode: this edge raises h3 and drops h1, or the reverse
  wire h3_edge = ~ph_reg;
  wire h1_edge = ph_reg;
  wire pin_reset = ~rs2_reg;
  wire hit_ctl = (paddr == `DCP_OFF_FLAGCTL);
  wire hit_stat = (paddr == `DCP_OFF_DSTAT);
  wire apb_access = psel & penable & ~pready;
  wire wr_fire = psel & penable & pready & pwrite & hit_ctl;
  wire take = cmd_valid & cmd_ready;
  wire [1:0] dir_sw = {ctl_reg[`DCP_DIR1], ctl_reg[`DCP_DIR0]};
  wire [1:0] out_sw = {ctl_reg[`DCP_OUT1], ctl_reg[`DCP_OUT0]};
  wire [2:0] boot_ws = link.boot_mode_select ? `DCP_WS_MC : `DCP_WS_MP;
  wire [31:0] ctl_rd = {ctl_reg[31:8], in_reg[1], ctl_reg[6:4], in_reg[0], ctl_reg[2:0]};
  wire [31:0] stat_rd = {25'h0, running, 1'b0, sig_sample, int_seen};

  // Pin outputs; flag and async drivers drop at once with the reset pin
  // asynchronous float
  assign link.dev_flag_oe = flag_dir_reg & {2{link.reset_n}};
  assign link.async_oe = async_oe_reg & link.reset_n;
  assign link.dev_flag_o = flag_o_reg;
  assign link.h1 = h1_reg;
  assign link.h3 = h3_reg;
  assign link.addr = addr_reg;
  assign link.addr_oe = addr_oe_reg;
  assign link.data_oe = data_oe_reg;
  assign link.strb_n = strb_n_reg;
  assign link.peripheral_io_strobe_n = peripheral_io_strobe_n_reg;
  assign link.rw_o = rw_reg;
  assign link.rw_oe = rw_oe_reg;
  assign link.interrupt_acknowledge_out_n = interrupt_acknowledge_out_n_reg;

  always_ff @(posedge mclk) begin
    ph_reg <= rst ? 1'b0 : ~ph_reg;
    h1_reg <= rst ? 1'b1 : ph_reg;
    h3_reg <= rst ? 1'b0 : ~ph_reg;
  end

  always_ff @(posedge mclk) begin
    rs1_reg <= rst ? 1'b0 : link.reset_n;
    rs2_reg <= rst ? 1'b0 : rs1_reg;
  end

  // APB handshake, answer in second access cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= apb_access;
      pslverr <= apb_access & ~hit_ctl & ~hit_stat;
      prdata <= (apb_access & hit_ctl) ? ctl_rd : ((apb_access & hit_stat) ? stat_rd : 32'h0);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      in_reg <= 2'b00;
      int_seen <= 4'h0;
    end else if (h3_edge) begin
      in_reg <= (~flag_dir_reg & link.flag_lvl) | (flag_dir_reg & in_reg);
      int_seen <= ~link.ext_int_n;
    end
  end

  // Sequencer, software flag word and pin drivers
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= ST_RESET;
      op_reg <= OP_STORE_INT;
      ctl_reg <= `DCP_FLAGCTL_RST;
      flag_o_reg <= 2'b00;
      flag_dir_reg <= 2'b00;
      async_oe_reg <= 1'b0;
      addr_reg <= `DCP_RESET_VEC;
      cmd_addr_reg <= `DCP_RESET_VEC;
      addr_oe_reg <= 1'b0;
      data_oe_reg <= 1'b0;
      strb_n_reg <= 2'b11;
      peripheral_io_strobe_n_reg <= 1'b1;
      rw_reg <= 1'b1;
      rw_oe_reg <= 1'b0;
      interrupt_acknowledge_out_n_reg <= 1'b1;
      busy_reg <= 1'b0;
      fetch_reg <= 1'b0;
      wait_reg <= 3'h0;
      ws_reg <= 3'h0;
      cmd_ready <= 1'b0;
      cmd_done <= 1'b0;
      sig_sample <= 1'b0;
      running <= 1'b0;
    end else begin
      cmd_done <= 1'b0;
      if (wr_fire) begin
        ctl_reg <= pwdata;
      end
      // software word reaches pins at h3
      if (h3_edge) begin
        flag_o_reg <= out_sw;
        flag_dir_reg <= dir_sw;
      end
      if (pin_reset) begin
        state_reg <= ST_RESET;
      end else begin
        case (state_reg)
          ST_RESET: begin
            if (h3_edge) begin
              state_reg <= ST_BOOT;
              busy_reg <= 1'b0;
              fetch_reg <= 1'b0;
            end
          end
          ST_BOOT: begin
            if (h3_edge) begin
              if (!busy_reg) begin
                busy_reg <= 1'b1;
                wait_reg <= boot_ws;
                addr_reg <= `DCP_RESET_VEC;
                addr_oe_reg <= 1'b1;
                strb_n_reg[0] <= 1'b0;
                rw_reg <= 1'b1;
                rw_oe_reg <= 1'b1;
              end else if (wait_reg != 3'h0) begin
                wait_reg <= wait_reg - 3'h1;
              end else begin
                busy_reg <= 1'b0;
                strb_n_reg[0] <= 1'b1;
                fetch_reg <= 1'b1;
                if (fetch_reg == `DCP_LAST_FETCH) begin
                  state_reg <= ST_IDLE;
                  addr_oe_reg <= 1'b0;
                  async_oe_reg <= 1'b1;
                  running <= 1'b1;
                  cmd_ready <= 1'b1;
                end
              end
            end
          end
          ST_IDLE: begin
            if (take) begin
              cmd_ready <= 1'b0;
              op_reg <= dcp_op_t'(cmd_op);
              cmd_addr_reg <= cmd_addr;
              ws_reg <= cmd_wait;
              busy_reg <= 1'b0;
              if (cmd_op == OP_SIGNAL) begin
                state_reg <= ST_SIG_LOW;
              end else if (cmd_op == OP_INTERRUPT_ACKNOWLEDGE_OUT) begin
                state_reg <= ST_INTERRUPT_ACKNOWLEDGE_OUT;
              end else begin
                state_reg <= ST_STORE_WAIT;
              end
            end
          end
          ST_STORE_WAIT: begin
            if (h3_edge) begin
              flag_o_reg[0] <= 1'b1;
              flag_dir_reg[0] <= 1'b1;
              ctl_reg[`DCP_OUT0] <= 1'b1;
              ctl_reg[`DCP_DIR0] <= 1'b1;
              if (!cmd_conflict) begin
                addr_reg <= cmd_addr_reg;
                addr_oe_reg <= 1'b1;
                data_oe_reg <= 1'b1;
                strb_n_reg[0] <= 1'b0;
                rw_reg <= 1'b0;
                rw_oe_reg <= 1'b1;
                state_reg <= ST_STORE;
              end
            end
          end
          ST_STORE: begin
            if (h3_edge) begin
              strb_n_reg[0] <= 1'b1;
              rw_reg <= 1'b1;
              addr_oe_reg <= 1'b0;
              data_oe_reg <= 1'b0;
              cmd_done <= 1'b1;
              cmd_ready <= 1'b1;
              state_reg <= ST_IDLE;
            end
          end
          ST_SIG_LOW: begin
            if (h3_edge) begin
              flag_o_reg[0] <= 1'b0;
              flag_dir_reg[0] <= 1'b1;
              ctl_reg[`DCP_OUT0] <= 1'b0;
              ctl_reg[`DCP_DIR0] <= 1'b1;
              state_reg <= ST_SIG_MID;
            end
          end
          // flag one sampled at h1 fall
          ST_SIG_MID: begin
            if (h3_edge) begin
              sig_sample <= link.flag_lvl[1];
              state_reg <= ST_SIG_HIGH;
            end
          end
          ST_SIG_HIGH: begin
            if (h3_edge) begin
              flag_o_reg[0] <= 1'b1;
              ctl_reg[`DCP_OUT0] <= 1'b1;
              cmd_done <= 1'b1;
              cmd_ready <= 1'b1;
              state_reg <= ST_IDLE;
            end
          end
          // acknowledge over bus cycle and waits
          ST_INTERRUPT_ACKNOWLEDGE_OUT: begin
            if (h1_edge) begin
              if (!busy_reg) begin
                busy_reg <= 1'b1;
                interrupt_acknowledge_out_n_reg <= 1'b0;
                wait_reg <= ws_reg;
              end else if (wait_reg != 3'h0) begin
                wait_reg <= wait_reg - 3'h1;
              end else begin
                busy_reg <= 1'b0;
                interrupt_acknowledge_out_n_reg <= 1'b1;
                cmd_done <= 1'b1;
                cmd_ready <= 1'b1;
                state_reg <= ST_IDLE;
              end
            end
          end
          default: begin
            state_reg <= ST_RESET;
          end
        endcase
      end
      // parking while the reset pin is low
      if (pin_reset) begin
        cmd_ready <= 1'b0;
        running <= 1'b0;
        async_oe_reg <= 1'b0;
        flag_dir_reg <= 2'b00;
        ctl_reg <= `DCP_FLAGCTL_RST;
        rw_oe_reg <= 1'b0;
        if (h1_edge) begin
          data_oe_reg <= 1'b0;
          interrupt_acknowledge_out_n_reg <= 1'b1;
        end
        if (h3_edge) begin
          addr_oe_reg <= 1'b0;
          strb_n_reg <= 2'b11;
          peripheral_io_strobe_n_reg <= 1'b1;
        end
      end
    end
  end
endmodule

// ==== hw/dcp_glue.sv ====
// Glue end: reset source, interrupt sources and peer flag driver
`timescale 1ns/1ps
module dcp_glue
  import dcp_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // APB slave for control and status
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  dcp_link_if.glue link
);
`include "dcp_cfg.svh"

  logic [31:0] ctrl_reg;
  logic [3:0] pend_reg;
  logic [3:0] int_n_reg;
  logic [3:0] cnt_reg;
  logic reset_n_reg;
  logic [1:0] f1_reg;
  logic h1_prev_reg;

  wire h1_rise = link.h1 & ~h1_prev_reg;
  wire hit_ctrl = (paddr == `DCP_OFF_GCTRL);
  wire hit_stat = (paddr == `DCP_OFF_GSTAT);
  wire apb_access = psel & penable & ~pready;
  wire wr_fire = psel & penable & pready & pwrite & hit_ctrl;
  wire [3:0] int_req = wr_fire ? pwdata[`DCP_G_INT_LO +: 4] : 4'h0;
  wire [31:0] stat_rd = {17'h0, link.rw_lvl, link.async_oe, link.data_oe, link.addr_oe,
    link.peripheral_io_strobe_n, link.strb_n, link.interrupt_acknowledge_out_n, reset_n_reg, link.flag_lvl, pend_reg};

  assign link.reset_n = reset_n_reg;
  assign link.boot_mode_select = ctrl_reg[`DCP_G_BOOT];
  assign link.ext_int_n = int_n_reg;
  assign link.glue_flag_o = {f1_reg[0], 1'b0};
  assign link.glue_flag_oe = {f1_reg[1], 1'b0};

  // APB handshake, answer in second access cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= apb_access;
      pslverr <= apb_access & ~hit_ctrl & ~hit_stat;
      prdata <= (apb_access & hit_ctrl) ? ctrl_reg : ((apb_access & hit_stat) ? stat_rd : 32'h0);
    end
  end

  // Control word, interrupt bits are strobes
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_reg <= `DCP_GCTRL_RST;
      // Phase one idles high in reset, so no false rise afterwards
      h1_prev_reg <= 1'b1;
    end else begin
      h1_prev_reg <= link.h1;
      if (wr_fire) begin
        ctrl_reg <= {pwdata[31:8], 4'h0, pwdata[3:0]};
      end
    end
  end

  // reset held at least ten h1 cycles, released at h1 fall
  always_ff @(posedge mclk) begin
    if (rst) begin
      reset_n_reg <= 1'b0;
      cnt_reg <= 4'h0;
    end else if (ctrl_reg[`DCP_G_HOLD] && reset_n_reg) begin
      reset_n_reg <= 1'b0;
      cnt_reg <= 4'h0;
    end else if (!reset_n_reg && h1_rise) begin
      if (cnt_reg != `DCP_RESET_HOLD) begin
        cnt_reg <= cnt_reg + 4'h1;
      end else if (!ctrl_reg[`DCP_G_HOLD]) begin
        reset_n_reg <= 1'b1;
      end
    end
  end

  // one h1 period per request, new request wins over clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      pend_reg <= 4'h0;
      int_n_reg <= 4'hf;
    end else if (h1_rise) begin
      int_n_reg <= ~pend_reg;
      pend_reg <= int_req;
    end else begin
      pend_reg <= pend_reg | int_req;
    end
  end

  // flag one changes only at h1 fall
  always_ff @(posedge mclk) begin
    if (rst) begin
      f1_reg <= 2'b00;
    end else if (h1_rise) begin
      f1_reg <= {ctrl_reg[`DCP_G_F1OE], ctrl_reg[`DCP_G_F1VAL]};
    end
  end
endmodule

// ==== tb/dcp_link_checker.sv ====
// Assertions on the pins between the processor and glue ends
`timescale 1ns/1ps
module dcp_link_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Link pins
  input wire logic h1,
  input wire logic h3,
  input wire logic reset_n,
  input wire logic [3:0] ext_int_n,
  input wire logic interrupt_acknowledge_out_n,
  input wire logic [1:0] strb_n,
  input wire logic peripheral_io_strobe_n,
  input wire logic rw_o,
  input wire logic rw_oe,
  input wire logic addr_oe,
  input wire logic data_oe,
  input wire logic async_oe,
  input wire logic [1:0] dev_flag_o,
  input wire logic [1:0] dev_flag_oe
);
  logic [4:0] lo_cnt;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Phase-one low cycles while the reset pin is held
  always_ff @(posedge mclk) begin
    if (rst || reset_n) lo_cnt <= 5'h00;
    else if (!h1 && lo_cnt != 5'h1f) lo_cnt <= lo_cnt + 5'h01;
  end
  // Store: strobe and address start at h3 with flag zero high, both end two cycles on
  sequence s_store_start;
    $fell(strb_n[0]) && !rw_o;
  endsequence
  sequence s_store_act;
    addr_oe && dev_flag_o[0] && h3;
  endsequence
  sequence s_store_done;
    strb_n[0] && !addr_oe;
  endsequence
  a_phase_comp: assert property (h3 == !h1) else $error("phases overlap");
  a_phase_toggle: assert property (!$past(rst) |-> h1 != $past(h1)) else $error("phase stuck");
  a_store_drive: assert property (s_store_start |-> s_store_act ##2 s_store_done)
    else $error("store pins wrong");
  a_flag_timing: assert property (reset_n && $past(reset_n) && $changed(dev_flag_o)
    |-> $rose(h3)) else $error("flag value off phase three");
  a_dir_timing: assert property (reset_n && $past(reset_n) && $changed(dev_flag_oe)
    |-> $rose(h3)) else $error("flag direction off phase three");
  a_flag_float: assert property (!reset_n |-> dev_flag_oe == 2'b00 && !async_oe)
    else $error("pins driven in reset");
  a_rw_float: assert property ((!reset_n)[*4] |-> !rw_oe)
    else $error("direction driven in reset");
  a_bus_park: assert property ((!reset_n)[*8] |-> !data_oe && !addr_oe && strb_n == 2'b11
    && peripheral_io_strobe_n && interrupt_acknowledge_out_n) else $error("bus not parked");
  a_interrupt_acknowledge_out_start: assert property ($fell(interrupt_acknowledge_out_n) |-> $rose(h1)) else $error("ack start");
  a_interrupt_acknowledge_out_end: assert property ($rose(interrupt_acknowledge_out_n) |-> $rose(h1)) else $error("ack end");
  a_int_pulse: assert property (|($past(ext_int_n) & ~ext_int_n) |=> $stable(ext_int_n)
    ##1 ext_int_n == 4'hf) else $error("interrupt pulse length");
  a_reset_hold: assert property ($rose(reset_n) |-> lo_cnt >= 5'd10 && $fell(h1))
    else $error("reset released early");
endmodule

// ==== tb/test_dsp_control_pin_logic.sv ====
// Self-checking bench for the processor and glue ends of the control-pin link
`timescale 1ns/1ps
`include "dcp_cfg.svh"
module test_dsp_control_pin_logic;
  import dcp_pkg::*;
  logic mclk, rst, d_psel, g_psel, penable, pwrite, cmd_valid, cmd_conflict, cmd_ready;
  logic d_pready, g_pready, d_perr, g_perr, cmd_done, sig_sample, running, v, l0, l1, held, pd1, i1;
  logic [11:0] paddr;
  logic [31:0] pwdata, d_prdata, g_prdata, w;
  logic [1:0] cmd_op;
  logic [23:0] cmd_addr, st_addr;
  logic [2:0] cmd_wait;
  logic [3:0] int_seen, seen;
  logic [7:0] rnd;
  logic [65:0] e;
  logic [65:0] exp_q[$];
  int err_count, compares, cycles, lowcnt, iackcnt, n;
  dcp_link_if link();
  dcp_device dcp_device_i (.mclk(mclk), .rst(rst), .psel(d_psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(d_prdata), .pready(d_pready),
    .pslverr(d_perr), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_conflict(cmd_conflict), .cmd_wait(cmd_wait), .cmd_ready(cmd_ready),
    .cmd_done(cmd_done), .sig_sample(sig_sample), .int_seen(int_seen), .running(running),
    .link(link.dev));
  dcp_glue dcp_glue_i (.mclk(mclk), .rst(rst), .psel(g_psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(g_prdata), .pready(g_pready),
    .pslverr(g_perr), .link(link.glue));
  dcp_link_checker dcp_link_checker_i (.mclk(mclk), .rst(rst), .h1(link.h1), .h3(link.h3),
    .reset_n(link.reset_n), .ext_int_n(link.ext_int_n), .interrupt_acknowledge_out_n(link.interrupt_acknowledge_out_n),
    .strb_n(link.strb_n), .peripheral_io_strobe_n(link.peripheral_io_strobe_n), .rw_o(link.rw_o), .rw_oe(link.rw_oe),
    .addr_oe(link.addr_oe), .data_oe(link.data_oe), .async_oe(link.async_oe),
    .dev_flag_o(link.dev_flag_o), .dev_flag_oe(link.dev_flag_oe));
  // Clock
  always #2.5 mclk = ~mclk;
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task check(input logic [32:0] seen_v, input logic [32:0] exp_v);
    compares++;
    if (seen_v !== exp_v) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen_v, exp_v);
    end
  endtask
  task stop_test();
    $display("Counts: %0d compares, %0d mismatches", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // One APB transfer on the device (g=0) or glue (g=1) slave
  task automatic apb(input logic g, input logic wr, input logic [11:0] a, input logic [31:0] d);
    d_psel <= !g;
    g_psel <= g;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (!(g ? g_pready : d_pready));
    d_psel <= 1'b0;
    g_psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  // Read with a noted expectation of {pslverr, prdata} under a mask
  task rd(input logic g, input logic [11:0] a, input logic [32:0] m, input logic [32:0] x);
    exp_q.push_back({m, x & m});
    apb(g, 1'b0, a, 32'h0);
  endtask
  // Instruction request, optional stall, then wait for completion
  task automatic cmd(input dcp_op_t op, input logic [2:0] ws, input int stall);
    held = 1'b0;
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= {rnd, ~rnd, rnd ^ 8'h5a};
    cmd_wait <= ws;
    cmd_conflict <= stall > 0;
    do begin
      @(posedge mclk);
    end while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    repeat (stall) begin
      @(posedge mclk);
      held = held | link.addr_oe;
    end
    cmd_conflict <= 1'b0;
    do begin
      @(posedge mclk);
    end while (cmd_done !== 1'b1);
    @(posedge mclk);
  endtask
  // Read results, strobe and acknowledge counters, store address capture
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      err_count++;
      stop_test();
    end
    if (penable && !pwrite && ((d_psel && d_pready) || (g_psel && g_pready))) begin
      e = exp_q.pop_front();
      check({d_psel ? d_perr : g_perr, d_psel ? d_prdata : g_prdata} & e[65:33], e[32:0]);
    end
    if (!link.reset_n) lowcnt <= 0;
    else if (!link.strb_n[0]) lowcnt <= lowcnt + 1;
    if (!link.interrupt_acknowledge_out_n) iackcnt <= iackcnt + 1;
    if (link.addr_oe && !link.strb_n[0] && !link.rw_o) st_addr <= link.addr;
  end
  // Main sequence
  initial begin
    {d_psel, g_psel, penable, pwrite, cmd_valid, cmd_conflict, paddr, pwdata} = '0;
    {cmd_op, cmd_addr, cmd_wait} = '0;
    {pd1, i1} = 2'b01;
    mclk = 1'b0;
    rst = 1'b1;
    rnd = 8'h48;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    repeat (30) @(posedge mclk);
    rd(1'b1, `DCP_OFF_GSTAT, 33'h1_0000_7ff0, 33'h0_0000_47b0);
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, 1'b1, `DCP_OFF_GCTRL, {30'h0, m[0], 1'b1});
      repeat (40) @(posedge mclk);
      rd(1'b0, `DCP_OFF_DSTAT, 33'h40, 33'h0);
      apb(1'b1, 1'b1, `DCP_OFF_GCTRL, {30'h0, m[0], 1'b0});
      n = 0;
      do begin
        @(posedge mclk);
        n++;
      end while (running !== 1'b1 && n < 400);
      repeat (2) @(posedge mclk);
      check({1'b0, 32'(lowcnt)}, m ? 33'd4 : 33'd32);
    end
    $display("Test boot done");
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      v = rnd[7];
      w = {24'h0, rnd & 8'h77};
      apb(1'b1, 1'b1, `DCP_OFF_GCTRL, {22'h0, 1'b1, v, 8'h02});
      apb(1'b0, 1'b1, `DCP_OFF_FLAGCTL, w);
      repeat (6) @(posedge mclk);
      l0 = w[1] ? w[2] : 1'b1;
      l1 = w[5] ? w[6] : v;
      // Input bit keeps its last sample while the pin drives
      i1 = (w[5] && pd1) ? i1 : v;
      pd1 = w[5];
      check({31'h0, link.flag_lvl}, {31'h0, l1, l0});
      rd(1'b0, `DCP_OFF_FLAGCTL, {1'b1, 32'hffff_ffff}, {1'b0, w | {24'h0, i1, 3'h0, 4'h8}});
    end
    rd(1'b0, 12'h008, {33{1'b1}}, {1'b1, 32'h0});
    $display("Test flags done");
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      apb(1'b0, 1'b1, `DCP_OFF_FLAGCTL, 32'h0000_0002);
      cmd(i[0] ? OP_STORE_FLOAT : OP_STORE_INT, 3'h0, i * 3);
      check({32'h0, held}, 33'h0);
      check({9'h0, st_addr}, {9'h0, cmd_addr});
      check({32'h0, link.flag_lvl[0]}, 33'h1);
    end
    $display("Test store done");
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, 1'b1, `DCP_OFF_GCTRL, {22'h0, 1'b1, i[0], 8'h02});
      repeat (4) @(posedge mclk);
      cmd(OP_SIGNAL, 3'h0, 0);
      check({32'h0, sig_sample}, {32'h0, i[0]});
      check({32'h0, link.flag_lvl[0]}, 33'h1);
    end
    $display("Test signal done");
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      iackcnt = 0;
      cmd(OP_INTERRUPT_ACKNOWLEDGE_OUT, rnd[2:0], 0);
      check(33'(iackcnt), 33'(2 * (1 + rnd[2:0])));
    end
    $display("Test acknowledge done");
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, 1'b1, `DCP_OFF_GCTRL, 32'h2 | (32'h10 << k));
      seen = 4'h0;
      repeat (8) begin
        @(posedge mclk);
        seen = seen | int_seen;
      end
      check({29'h0, seen}, 33'h1 << k);
    end
    $display("Test interrupts done");
    stop_test();
  end
endmodule
